// file: gtch_pkg.sv
package gtch_pkg;
  // API frame framing.
  localparam logic [7:0]  START_DELIM      = 8'h7E;
  localparam logic [7:0]  TYPE_EXPLICIT_TX = 8'h11;
  localparam logic [7:0]  TYPE_EXPLICIT_RX = 8'h91;
  localparam logic [7:0]  TYPE_TX_STATUS   = 8'h8B;
  localparam logic [7:0]  CHECKSUM_BASE    = 8'hFF;
  // Addressing of group-table requests.
  localparam logic [7:0]  MGMT_ENDPOINT    = 8'hE6;
  localparam logic [15:0] GROUP_CLUSTER    = 16'h0006;
  localparam logic [15:0] GROUP_RSP_CLUSTER = 16'h8006;
  localparam logic [15:0] VENDOR_PROFILE   = 16'hC105;
  localparam logic [15:0] SHORT_ADDR_UNK   = 16'hFFFE;
  localparam logic [7:0]  RX_OPTIONS       = 8'h00;
  // Cluster header values.
  localparam logic [7:0]  FC_CLUSTER_SPEC  = 8'h01;
  localparam logic [7:0]  FC_SERVER_TO_CLIENT = 8'h08;
  localparam logic [7:0]  FC_CLIENT_TO_SERVER = 8'h00;
  localparam logic [7:0]  CMD_GET_MEMBERSHIP = 8'h02;
  localparam logic [7:0]  CMD_REMOVE_GROUP = 8'h03;
  localparam logic [7:0]  CAPACITY_UNKNOWN = 8'hFF;
  localparam logic [7:0]  STATUS_SUCCESS   = 8'h00;
  localparam logic [7:0]  STATUS_NOT_FOUND = 8'h8B;
  // Request byte positions, counted after the two length bytes.
  localparam int unsigned REQ_POS_TYPE     = 0;
  localparam int unsigned REQ_POS_TAG      = 1;
  localparam int unsigned REQ_POS_SRC_EP   = 12;
  localparam int unsigned REQ_POS_DST_EP   = 13;
  localparam int unsigned REQ_POS_CL_HI    = 14;
  localparam int unsigned REQ_POS_CL_LO    = 15;
  localparam int unsigned REQ_POS_PR_HI    = 16;
  localparam int unsigned REQ_POS_PR_LO    = 17;
  localparam int unsigned REQ_POS_FC       = 20;
  localparam int unsigned REQ_POS_SEQ      = 21;
  localparam int unsigned REQ_POS_CMD      = 22;
  localparam int unsigned REQ_POS_PAYLOAD  = 23;
  // Response layout: fixed prefix of type, 64-bit address, short address,
  // endpoints, cluster, profile and options, then the cluster header.
  localparam int unsigned RSP_PREFIX_LEN   = 18;
  localparam int unsigned STATUS_FRAME_LEN = 7;
  localparam int unsigned MAX_GROUPS       = 8;
endpackage

// file: gtch_link_if.sv
`timescale 1ns/1ps
// Byte streams between host and device: request bytes toward the device and
// response bytes toward the host, each with valid and ready.
interface gtch_link_if;
  logic       req_valid;
  logic       req_ready;
  logic [7:0] req_data;
  logic       rsp_valid;
  logic       rsp_ready;
  logic [7:0] rsp_data;
  modport device (input req_valid, output req_ready, input req_data,
                  output rsp_valid, input rsp_ready, output rsp_data);
  modport host (output req_valid, input req_ready, output req_data,
                input rsp_valid, output rsp_ready, input rsp_data);
endinterface

// file: gtch_device.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Host sends requests from management endpoint to target endpoint, group cluster.
// - Host sends cluster-specific client-to-server frame control.
// - Three-byte cluster header; sequence number echoed back.
// - Response frame control 0x09, command identifier echoed.
// - Response goes out as explicit receive frame.
// - Endpoints swapped, response cluster 0x8006.
// - Membership query returns listed groups held by endpoint.
// - Membership payload: capacity 0xFF, count, groups.
// - Remove deletes the endpoint's entry for group.
// - Remove answer: status, then group number little-endian.
// - Status frame follows unless tag zero or no room.
// - Zero count returns all groups of endpoint.
// - No matching entry reports status 0x8b.
module gtch_device #(
  parameter int unsigned TABLE_DEPTH = 8,  // Group table entries.
  parameter int unsigned FRAME_MAX   = 48  // Longest request frame kept.
) (
  input  wire logic       core_clk,     // System clock.
  input  wire logic       reset_n,      // Asynchronous reset, active low.
  input  wire logic       clk_en,       // Freezes all state while low.
  gtch_link_if.device     link,         // Serial API byte streams.
  input  wire logic       add_valid,    // Local load of one table entry.
  input  wire logic [7:0] add_endpoint, // Endpoint of entry to load.
  input  wire logic [15:0] add_group,   // Group number of entry to load.
  input  wire logic       tx_room,      // Serial transmit buffer has room.
  output logic            busy          // A request is being answered.
);
  typedef enum logic [2:0] {
    GTCH_ST_DELIM = 3'b000, GTCH_ST_LEN_HI = 3'b001, GTCH_ST_LEN_LO = 3'b010,
    GTCH_ST_BODY = 3'b011, GTCH_ST_SUM = 3'b100, GTCH_ST_EXEC = 3'b101,
    GTCH_ST_SEND = 3'b110
  } gtch_state_t;

  gtch_state_t state, next_state;
  logic [7:0]  frame [FRAME_MAX];
  logic [7:0]  tbl_ep [TABLE_DEPTH];
  logic [15:0] tbl_grp [TABLE_DEPTH];
  logic [TABLE_DEPTH-1:0] tbl_used, next_tbl_used, hit_mask, next_hit_mask;
  logic [15:0] len, next_len, idx, next_idx;
  logic [7:0]  sum, next_sum;
  logic        with_status, next_with_status;
  logic        rsp_is_status, next_rsp_is_status;
  logic [7:0]  rm_status, next_rm_status;
  logic [7:0]  out_data, next_out_data;
  logic        out_valid, next_out_valid;
  logic [7:0]  buf_data [2];
  logic [1:0]  buf_cnt;
  logic        buf_rd, buf_wr;
  logic        buf_ptr_w, buf_ptr_r;

  // Reads a little-endian group number from the stored request.
  function automatic logic [15:0] req_group(input logic [7:0] f [FRAME_MAX],
                                            input int unsigned pos);
    return {f[pos+1], f[pos]};
  endfunction

  // True when a table entry matches an endpoint and a group number.
  function automatic logic entry_hit(input logic used, input logic [7:0] ep,
      input logic [15:0] grp, input logic [7:0] want_ep, input logic [15:0] want_grp);
    return used && ep == want_ep && grp == want_grp;
  endfunction

  logic [7:0]  t_ep, t_cmd, t_cnt;
  logic        req_ok;
  logic [7:0]  hit_cnt;
  assign t_ep  = frame[gtch_pkg::REQ_POS_DST_EP];
  assign t_cmd = frame[gtch_pkg::REQ_POS_CMD];
  assign t_cnt = frame[gtch_pkg::REQ_POS_PAYLOAD];
  // Requests not aimed at the group cluster are dropped silently.
  assign req_ok = frame[gtch_pkg::REQ_POS_TYPE] == gtch_pkg::TYPE_EXPLICIT_TX
    && frame[gtch_pkg::REQ_POS_SRC_EP] == gtch_pkg::MGMT_ENDPOINT
    && {frame[gtch_pkg::REQ_POS_CL_HI], frame[gtch_pkg::REQ_POS_CL_LO]}
       == gtch_pkg::GROUP_CLUSTER
    && {frame[gtch_pkg::REQ_POS_PR_HI], frame[gtch_pkg::REQ_POS_PR_LO]}
       == gtch_pkg::VENDOR_PROFILE
    && (t_cmd == gtch_pkg::CMD_GET_MEMBERSHIP || t_cmd == gtch_pkg::CMD_REMOVE_GROUP);

  // Counts matched entries for the membership count byte.
  always_comb begin
    hit_cnt = 8'h00;
    for (int i = 0; i < TABLE_DEPTH; i++) begin
      hit_cnt = hit_cnt + {7'h00, hit_mask[i]};
    end
  end

  // Position of the byte just past the membership groups.
  logic [15:0] rsp_len, grp_end;
  assign grp_end = 16'(gtch_pkg::RSP_PREFIX_LEN + 5) + {7'h00, hit_cnt, 1'b0};
  assign rsp_len = (t_cmd == gtch_pkg::CMD_REMOVE_GROUP) ?
                   16'(gtch_pkg::RSP_PREFIX_LEN + 6) : grp_end;

  // Selects the k-th matching group number for group bytes 2k and 2k+1.
  function automatic logic [15:0] nth_hit(input logic [TABLE_DEPTH-1:0] m,
      input logic [15:0] tg [TABLE_DEPTH], input logic [7:0] k);
    logic [7:0]  c;
    logic [15:0] r;
    c = 8'h00;
    r = 16'h0000;
    for (int i = 0; i < TABLE_DEPTH; i++) begin
      if (m[i]) begin
        if (c == k) r = tg[i];
        c = c + 8'h01;
      end
    end
    return r;
  endfunction

  // Byte of the outgoing response at position p, checksum excluded.
  function automatic logic [7:0] rsp_byte(input logic [15:0] p, input logic [7:0] grp_b);
    logic [7:0] b;
    b = 8'h00;
    case (p)
      16'h0000: b = gtch_pkg::TYPE_EXPLICIT_RX;
      16'h0009: b = gtch_pkg::SHORT_ADDR_UNK[15:8];
      16'h000A: b = gtch_pkg::SHORT_ADDR_UNK[7:0];
      16'h000B: b = t_ep;
      16'h000C: b = frame[gtch_pkg::REQ_POS_SRC_EP];
      16'h000D: b = gtch_pkg::GROUP_RSP_CLUSTER[15:8];
      16'h000E: b = gtch_pkg::GROUP_RSP_CLUSTER[7:0];
      16'h000F: b = gtch_pkg::VENDOR_PROFILE[15:8];
      16'h0010: b = gtch_pkg::VENDOR_PROFILE[7:0];
      16'h0011: b = gtch_pkg::RX_OPTIONS;
      16'h0012: b = gtch_pkg::FC_CLUSTER_SPEC | gtch_pkg::FC_SERVER_TO_CLIENT;
      16'h0013: b = frame[gtch_pkg::REQ_POS_SEQ];
      16'h0014: b = t_cmd;
      16'h0015: b = (t_cmd == gtch_pkg::CMD_REMOVE_GROUP) ? rm_status
                    : gtch_pkg::CAPACITY_UNKNOWN;
      16'h0016: b = (t_cmd == gtch_pkg::CMD_REMOVE_GROUP) ?
                    frame[gtch_pkg::REQ_POS_PAYLOAD] : hit_cnt;
      16'h0017: b = (t_cmd == gtch_pkg::CMD_REMOVE_GROUP) ?
                    frame[gtch_pkg::REQ_POS_PAYLOAD+1] : grp_b;
      default: begin
        if (p >= 16'h0001 && p <= 16'h0008) b = frame[p[4:0] + 5'd2];
        else b = grp_b;
      end
    endcase
    return b;
  endfunction

  // Byte of the transmit-status frame at position p.
  function automatic logic [7:0] status_byte(input logic [15:0] p);
    logic [7:0] b;
    b = 8'h00;
    case (p)
      16'h0000: b = gtch_pkg::TYPE_TX_STATUS;
      16'h0001: b = frame[gtch_pkg::REQ_POS_TAG];
      16'h0002: b = gtch_pkg::SHORT_ADDR_UNK[15:8];
      16'h0003: b = gtch_pkg::SHORT_ADDR_UNK[7:0];
      default:  b = 8'h00;
    endcase
    return b;
  endfunction

  logic [15:0] body_len, sel_grp, gidx;
  logic [7:0]  body_b, gpos;
  assign body_len = rsp_is_status ? 16'(gtch_pkg::STATUS_FRAME_LEN) : rsp_len;
  assign gidx     = idx - 16'(gtch_pkg::RSP_PREFIX_LEN + 8); // Zero at the first group byte.
  assign gpos     = gidx[8:1];
  assign sel_grp  = nth_hit(hit_mask, tbl_grp, gpos);
  // Picks the outgoing body byte; a process, so that the stored request bytes
  // read inside the functions also wake it up.
  always_comb begin
    body_b = rsp_is_status ? status_byte(idx - 16'd3) :
             rsp_byte(idx - 16'd3, gidx[0] ? sel_grp[15:8] : sel_grp[7:0]);
  end

  // Handshake, buffer control and activity outputs.
  assign busy     = state == GTCH_ST_EXEC || state == GTCH_ST_SEND;
  assign buf_wr   = out_valid && buf_cnt != 2'd2;
  assign buf_rd   = buf_cnt != 2'd0 && link.rsp_ready;
  assign link.req_ready = state != GTCH_ST_EXEC && state != GTCH_ST_SEND;
  assign link.rsp_valid = buf_cnt != 2'd0;
  assign link.rsp_data  = buf_data[buf_ptr_r];

  // Next-state logic: receive, check, execute, then emit framed answers.
  always_comb begin
    next_state = state;
    next_len = len;
    next_idx = idx;
    next_sum = sum;
    next_tbl_used = tbl_used;
    next_hit_mask = hit_mask;
    next_with_status = with_status;
    next_rsp_is_status = rsp_is_status;
    next_rm_status = rm_status;
    next_out_data = out_data;
    next_out_valid = out_valid && !buf_wr;
    if (add_valid) begin
      for (int i = TABLE_DEPTH - 1; i >= 0; i--) begin
        if (!tbl_used[i]) next_tbl_used = tbl_used | (TABLE_DEPTH'(1) << i);
      end
    end
    case (state)
      GTCH_ST_DELIM: if (link.req_valid && link.req_data == gtch_pkg::START_DELIM) begin
        next_state = GTCH_ST_LEN_HI;
      end
      GTCH_ST_LEN_HI: if (link.req_valid) begin
        next_len = {link.req_data, 8'h00};
        next_state = GTCH_ST_LEN_LO;
      end
      GTCH_ST_LEN_LO: if (link.req_valid) begin
        next_len = {len[15:8], link.req_data};
        next_idx = 16'h0000;
        next_sum = 8'h00;
        next_state = ({len[15:8], link.req_data} == 16'h0000) ? GTCH_ST_DELIM : GTCH_ST_BODY;
      end
      GTCH_ST_BODY: if (link.req_valid) begin
        next_sum = sum + link.req_data;
        next_idx = idx + 16'h0001;
        if (idx + 16'h0001 == len) next_state = GTCH_ST_SUM;
      end
      GTCH_ST_SUM: if (link.req_valid) begin
        // Bad checksum returns to hunting; a foreign request does so from GTCH_ST_EXEC.
        next_state = GTCH_ST_DELIM;
        if (8'(sum + link.req_data) == gtch_pkg::CHECKSUM_BASE) begin
          next_state = GTCH_ST_EXEC;
        end
      end
      GTCH_ST_EXEC: begin
        next_state = GTCH_ST_DELIM;
        next_hit_mask = '0;
        next_rm_status = gtch_pkg::STATUS_NOT_FOUND;
        for (int i = 0; i < TABLE_DEPTH; i++) begin
          if (t_cmd == gtch_pkg::CMD_REMOVE_GROUP) begin
            // A foreign frame must not touch the table.
            if (req_ok && entry_hit(tbl_used[i], tbl_ep[i], tbl_grp[i], t_ep,
                                    req_group(frame, gtch_pkg::REQ_POS_PAYLOAD))) begin
              next_tbl_used[i] = 1'b0;
              next_rm_status = gtch_pkg::STATUS_SUCCESS;
            end
          end else if (t_cnt == 8'h00) begin
            next_hit_mask[i] = tbl_used[i] && tbl_ep[i] == t_ep;
          end else begin
            for (int j = 0; j < gtch_pkg::MAX_GROUPS; j++) begin
              if (j < t_cnt && entry_hit(tbl_used[i], tbl_ep[i], tbl_grp[i], t_ep,
                  req_group(frame, gtch_pkg::REQ_POS_PAYLOAD + 1 + 2 * j)))
                next_hit_mask[i] = 1'b1;
            end
          end
        end
        if (req_ok) begin
          next_state = GTCH_ST_SEND;
          next_idx = 16'h0000;
          next_sum = 8'h00;
          next_rsp_is_status = 1'b0;
          next_with_status = frame[gtch_pkg::REQ_POS_TAG] != 8'h00 && tx_room;
        end
      end
      GTCH_ST_SEND: if (!out_valid || buf_wr) begin
        next_out_valid = 1'b1;
        next_idx = idx + 16'h0001;
        if (idx == 16'h0000) next_out_data = gtch_pkg::START_DELIM;
        else if (idx == 16'h0001) next_out_data = body_len[15:8];
        else if (idx == 16'h0002) next_out_data = body_len[7:0];
        else if (idx < body_len + 16'd3) begin
          next_out_data = body_b;
          next_sum = sum + body_b;
        end else begin
          next_out_data = gtch_pkg::CHECKSUM_BASE - sum;
          next_idx = 16'h0000;
          next_sum = 8'h00;
          if (!rsp_is_status && with_status) next_rsp_is_status = 1'b1;
          else next_state = GTCH_ST_DELIM;
        end
      end
      default: next_state = GTCH_ST_DELIM;
    endcase
  end

  // Registers the control state.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= GTCH_ST_DELIM;
      len <= 16'h0000;
      idx <= 16'h0000;
      sum <= 8'h00;
      tbl_used <= '0;
      hit_mask <= '0;
      with_status <= 1'b0;
      rsp_is_status <= 1'b0;
      rm_status <= 8'h00;
      out_data <= 8'h00;
      out_valid <= 1'b0;
      buf_cnt <= 2'd0;
      buf_ptr_w <= 1'b0;
      buf_ptr_r <= 1'b0;
    end else if (clk_en) begin
      state <= next_state;
      len <= next_len;
      idx <= next_idx;
      sum <= next_sum;
      tbl_used <= next_tbl_used;
      hit_mask <= next_hit_mask;
      with_status <= next_with_status;
      rsp_is_status <= next_rsp_is_status;
      rm_status <= next_rm_status;
      out_data <= next_out_data;
      out_valid <= next_out_valid;
      buf_cnt <= buf_cnt + {1'b0, buf_wr} - {1'b0, buf_rd};
      buf_ptr_w <= buf_ptr_w ^ buf_wr;
      buf_ptr_r <= buf_ptr_r ^ buf_rd;
    end
  end

  // Storage arrays: request bytes, table contents and the two-entry buffer.
  always_ff @(posedge core_clk) begin
    if (clk_en) begin
      if (state == GTCH_ST_BODY && link.req_valid && idx < 16'(FRAME_MAX)) begin
        frame[idx[5:0]] <= link.req_data;
      end
      for (int i = 0; i < TABLE_DEPTH; i++) begin
        if (add_valid && !tbl_used[i] && next_tbl_used[i]) begin
          tbl_ep[i] <= add_endpoint;
          tbl_grp[i] <= add_group;
        end
      end
      if (buf_wr) buf_data[buf_ptr_w] <= out_data;
    end
  end
endmodule

// file: gtch_host.sv
`timescale 1ns/1ps
// Host end: frames one group-table request and passes answer bytes back.
module gtch_host (
  input  wire logic        core_clk,   // System clock.
  input  wire logic        reset_n,    // Asynchronous reset, active low.
  input  wire logic        clk_en,     // Freezes all state while low.
  gtch_link_if.host        link,       // Serial API byte streams.
  input  wire logic        go,         // Start one request, one-cycle pulse.
  input  wire logic [7:0]  cmd,        // Command identifier.
  input  wire logic [7:0]  target_ep,  // Target endpoint.
  input  wire logic [7:0]  seq,        // Transaction sequence number.
  input  wire logic [7:0]  request_tag, // Frame tag, zero suppresses status.
  input  wire logic [15:0] group_number, // Group for remove or single query.
  input  wire logic        query_all,  // Membership query with count zero.
  output logic             ready,      // Idle and able to start.
  output logic             rx_valid,   // Answer byte valid.
  output logic [7:0]       rx_data     // Answer byte.
);
  typedef enum logic [1:0] {GTCH_H_IDLE = 2'b00, GTCH_H_SEND = 2'b01} gtch_hstate_t;
  gtch_hstate_t state, next_state;
  logic [5:0] idx, next_idx;
  logic [7:0] sum, next_sum;
  logic [7:0] r_cmd, r_ep, r_seq, r_tag;
  logic [15:0] r_grp;
  logic        r_all;
  logic [7:0]  body_len, b;
  logic        rx_v, next_rx_v;
  logic [7:0]  rx_d, next_rx_d;

  // Body: type, tag, unknown long and short address, endpoints, cluster,
  // profile, radius, options, cluster header and payload.
  always_comb begin
    body_len = (r_cmd == gtch_pkg::CMD_REMOVE_GROUP) ? 8'd25 : (r_all ? 8'd24 : 8'd26);
    b = 8'h00;
    case (idx)
      6'd3:  b = gtch_pkg::TYPE_EXPLICIT_TX;
      6'd4:  b = r_tag;
      6'd13: b = gtch_pkg::SHORT_ADDR_UNK[15:8];
      6'd14: b = gtch_pkg::SHORT_ADDR_UNK[7:0];
      6'd15: b = gtch_pkg::MGMT_ENDPOINT;
      6'd16: b = r_ep;
      6'd17: b = gtch_pkg::GROUP_CLUSTER[15:8];
      6'd18: b = gtch_pkg::GROUP_CLUSTER[7:0];
      6'd19: b = gtch_pkg::VENDOR_PROFILE[15:8];
      6'd20: b = gtch_pkg::VENDOR_PROFILE[7:0];
      6'd23: b = gtch_pkg::FC_CLUSTER_SPEC | gtch_pkg::FC_CLIENT_TO_SERVER;
      6'd24: b = r_seq;
      6'd25: b = r_cmd;
      6'd26: b = (r_cmd == gtch_pkg::CMD_REMOVE_GROUP) ? r_grp[7:0]
                 : (r_all ? 8'h00 : 8'h01);
      6'd27: b = (r_cmd == gtch_pkg::CMD_REMOVE_GROUP) ? r_grp[15:8] : r_grp[7:0];
      6'd28: b = r_grp[15:8];
      default: b = 8'h00;
    endcase
  end

  assign ready = state == GTCH_H_IDLE;
  assign link.rsp_ready = !rx_v;
  assign rx_valid = rx_v;
  assign rx_data = rx_d;
  assign link.req_valid = state == GTCH_H_SEND;
  assign link.req_data = (idx == 6'd0) ? gtch_pkg::START_DELIM :
                         (idx == 6'd1) ? 8'h00 :
                         (idx == 6'd2) ? body_len :
                         (idx == 6'(body_len + 8'd3)) ? 8'(gtch_pkg::CHECKSUM_BASE - sum) :
                         b;

  // Next values for the sender and the answer holding register.
  always_comb begin
    next_state = state;
    next_idx = idx;
    next_sum = sum;
    next_rx_v = rx_v && rx_v;
    next_rx_d = rx_d;
    if (rx_v) next_rx_v = 1'b0;
    if (link.rsp_valid && !rx_v) begin
      next_rx_v = 1'b1;
      next_rx_d = link.rsp_data;
    end
    case (state)
      GTCH_H_IDLE: if (go) begin
        next_state = GTCH_H_SEND;
        next_idx = 6'd0;
        next_sum = 8'h00;
      end
      GTCH_H_SEND: if (link.req_ready) begin
        next_idx = idx + 6'd1;
        if (idx >= 6'd3) next_sum = sum + b;
        if (idx == 6'(body_len + 8'd3)) next_state = GTCH_H_IDLE;
      end
      default: next_state = GTCH_H_IDLE;
    endcase
  end

  // Registers the state and latches the request at start.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= GTCH_H_IDLE;
      idx <= 6'd0;
      sum <= 8'h00;
      rx_v <= 1'b0;
      rx_d <= 8'h00;
      r_cmd <= 8'h00;
      r_ep <= 8'h00;
      r_seq <= 8'h00;
      r_tag <= 8'h00;
      r_grp <= 16'h0000;
      r_all <= 1'b0;
    end else if (clk_en) begin
      state <= next_state;
      idx <= next_idx;
      sum <= next_sum;
      rx_v <= next_rx_v;
      rx_d <= next_rx_d;
      if (state == GTCH_H_IDLE && go) begin
        r_cmd <= cmd;
        r_ep <= target_ep;
        r_seq <= seq;
        r_tag <= request_tag;
        r_grp <= group_number;
        r_all <= query_all && cmd == gtch_pkg::CMD_GET_MEMBERSHIP;
      end
    end
  end
endmodule

// file: gtch_link_assertions.sv
`timescale 1ns/1ps
// Checks response framing and handshakes on both byte streams between the two ends.
module gtch_link_assertions (
  input wire logic       core_clk,  // System clock.
  input wire logic       reset_n,   // Asynchronous reset, active low.
  input wire logic       req_valid, // Request byte valid.
  input wire logic       req_ready, // Request byte taken.
  input wire logic [7:0] req_data,  // Request byte.
  input wire logic       rsp_valid, // Response byte valid.
  input wire logic       rsp_ready, // Response byte taken.
  input wire logic [7:0] rsp_data   // Response byte.
);
  logic [15:0] rpos, next_rpos;
  logic [15:0] rlen, next_rlen;
  logic [7:0]  rsum, next_rsum;
  logic [7:0]  ftype, next_ftype;
  // Tracks position, length, type and running sum of each response frame.
  always_comb begin
    next_rpos  = rpos;
    next_rlen  = rlen;
    next_rsum  = rsum;
    next_ftype = ftype;
    if (rsp_valid && rsp_ready) begin
      next_rpos = (rpos > 16'h0002 && rpos == rlen + 16'h0003) ? 16'h0000 : rpos + 16'h0001;
      if (rpos == 16'h0001) next_rlen[15:8] = rsp_data;
      if (rpos == 16'h0002) next_rlen[7:0] = rsp_data;
      if (rpos == 16'h0003) next_ftype = rsp_data;
      next_rsum = (rpos < 16'h0003) ? 8'h00 : rsum + rsp_data;
    end
  end
  // Registers the frame tracking state.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rpos  <= 16'h0000;
      rlen  <= 16'h0000;
      rsum  <= 8'h00;
      ftype <= 8'h00;
    end else begin
      rpos  <= next_rpos;
      rlen  <= next_rlen;
      rsum  <= next_rsum;
      ftype <= next_ftype;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence s_at(int p);
    rsp_valid && rsp_ready && rpos == p;
  endsequence
  sequence s_last;
    rsp_valid && rsp_ready && rpos > 16'h0002 && rpos == rlen + 16'h0003;
  endsequence
  a_rsp_hold: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data))
    else $error("Response byte changed while stalled.");
  a_req_hold: assert property (req_valid && !req_ready |=> req_valid && $stable(req_data))
    else $error("Request byte changed while stalled.");
  a_rsp_start: assert property (s_at(0) |-> rsp_data == gtch_pkg::START_DELIM)
    else $error("Response frame without start delimiter.");
  a_rsp_type: assert property (s_at(3) |-> rsp_data inside {8'h91, 8'h8B})
    else $error("Response frame of unexpected type.");
  a_src_ep: assert property (s_at(15) ##0 ftype == 8'h91 |-> rsp_data == 8'hE6)
    else $error("Response target endpoint is not the management one.");
  a_rsp_cluster: assert property (s_at(16) ##0 ftype == 8'h91 |-> rsp_data == 8'h80)
    else $error("Response cluster high byte wrong.");
  a_rsp_fc: assert property (s_at(21) ##0 ftype == 8'h91 |-> rsp_data == 8'h09)
    else $error("Response frame control wrong.");
  a_rsp_sum: assert property (s_last |-> 8'(rsum + rsp_data) == 8'hFF)
    else $error("Response checksum wrong.");
  a_status_len: assert property (s_at(4) ##0 ftype == 8'h8B |-> rlen == 16'h0007)
    else $error("Status frame length wrong.");
endmodule

// file: tb.sv
`timescale 1ns/1ps
// Sends group-table requests through the host end and checks the answers.
module tb;
  logic        core_clk = 1'b0;
  logic        reset_n  = 1'b0;
  logic        go       = 1'b0;
  logic [7:0]  cmd      = 8'h00;
  logic [7:0]  tep      = 8'h00;
  logic [7:0]  seq      = 8'h00;
  logic [7:0]  tag      = 8'h00;
  logic [15:0] grp      = 16'h0000;
  logic        qall     = 1'b0;
  logic        add_v    = 1'b0;
  logic [7:0]  add_ep   = 8'h00;
  logic [15:0] add_g    = 16'h0000;
  logic        room     = 1'b1;
  logic        busy, ready, rx_valid;
  logic [7:0]  rx_data;
  logic [7:0]  q[$];
  logic [7:0]  rq[$];
  int          n_fail   = 0;
  int          checked  = 0;
  gtch_link_if link ();
  // Clock of 25 ns period.
  always #12.5 core_clk = ~core_clk;
  gtch_device gtch_device_i (.core_clk(core_clk), .reset_n(reset_n), .clk_en(1'b1),
    .link(link), .add_valid(add_v), .add_endpoint(add_ep), .add_group(add_g),
    .tx_room(room), .busy(busy));
  gtch_host gtch_host_i (.core_clk(core_clk), .reset_n(reset_n), .clk_en(1'b1),
    .link(link), .go(go), .cmd(cmd), .target_ep(tep), .seq(seq), .request_tag(tag),
    .group_number(grp), .query_all(qall), .ready(ready), .rx_valid(rx_valid),
    .rx_data(rx_data));
  gtch_link_assertions gtch_link_assertions_i (.core_clk(core_clk), .reset_n(reset_n),
    .req_valid(link.req_valid), .req_ready(link.req_ready), .req_data(link.req_data),
    .rsp_valid(link.rsp_valid), .rsp_ready(link.rsp_ready), .rsp_data(link.rsp_data));
  // Collects every response byte on the link and every byte the host hands on.
  always @(posedge core_clk) begin
    if (link.rsp_valid === 1'b1 && link.rsp_ready === 1'b1) q.push_back(link.rsp_data);
    if (rx_valid === 1'b1) rq.push_back(rx_data);
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic add(input logic [7:0] ep, input logic [15:0] g);
    add_v  <= 1'b1;
    add_ep <= ep;
    add_g  <= g;
    @(posedge core_clk);
    add_v <= 1'b0;
    @(posedge core_clk);
  endtask
  // Sends one request, waits for the answer and checks every frame of it.
  task automatic req(input logic [7:0] c, e, s, t, input logic [15:0] g, input logic a, r,
                     input logic [7:0] exp[$], input logic st);
    int         i;
    int         idle;
    int         len;
    logic [7:0] sum;
    for (i = 0; i < 200 && ready !== 1'b1; i++) @(negedge core_clk);
    @(posedge core_clk);
    q = {};
    rq = {};
    {cmd, tep, seq, tag, grp, qall, room} <= {c, e, s, t, g, a, r};
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    i = 0;
    idle = 0;
    // Busy drops while the last bytes still sit in the buffer, so the answer
    // counts as complete only after four quiet cycles.
    do begin
      @(negedge core_clk);
      i++;
      if (q.size() != 0 && busy === 1'b0 && link.rsp_valid === 1'b0 && rx_valid === 1'b0)
        idle++;
      else
        idle = 0;
    end while (idle < 4 && i < 900);
    if (i >= 900 || ready !== 1'b1) begin
      n_fail++;
      $display("[ERR] %0t no complete answer", $time);
      return;
    end
    len = {q[1], q[2]};
    chk(q[0], 8'h7E);
    chk(q[3], 8'h91);
    chk({q[14], q[15]}, {e, 8'hE6});
    chk({q[16], q[17]}, 16'h8006);
    chk({q[21], q[22]}, {8'h09, s});
    chk(q[23], c);
    chk(16'(len), 16'(21 + exp.size()));
    for (i = 0; i < exp.size(); i++) chk(q[24 + i], exp[i]);
    sum = 8'h00;
    for (i = 3; i < len + 4; i++) sum += q[i];
    chk(sum, 8'hFF);
    chk(16'(q.size()), 16'(st ? len + 15 : len + 4));
    if (st) chk({q[len + 7], q[len + 8]}, {8'h8B, t});
    chk(16'(rq.size()), 16'(q.size()));
    for (i = 0; i < q.size() && i < rq.size(); i++) chk(rq[i], q[i]);
  endtask
  // Loads the table, then queries, removes and queries again.
  initial begin
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    add(8'hE7, 16'h1234);
    add(8'hE7, 16'h5678);
    add(8'hE8, 16'h1234);
    req(8'h02, 8'hE7, 8'h11, 8'h01, 16'h0000, 1'b1, 1'b1,
        {8'hFF, 8'h02, 8'h34, 8'h12, 8'h78, 8'h56}, 1'b1);
    req(8'h02, 8'hE7, 8'h12, 8'h00, 16'h5678, 1'b0, 1'b1, {8'hFF, 8'h01, 8'h78, 8'h56}, 1'b0);
    req(8'h03, 8'hE7, 8'h13, 8'h05, 16'h1234, 1'b0, 1'b0, {8'h00, 8'h34, 8'h12}, 1'b0);
    req(8'h03, 8'hE7, 8'h14, 8'h06, 16'h1234, 1'b0, 1'b1, {8'h8B, 8'h34, 8'h12}, 1'b1);
    req(8'h02, 8'hE7, 8'h15, 8'h07, 16'h1234, 1'b0, 1'b1, {8'hFF, 8'h00}, 1'b1);
    req(8'h02, 8'hE8, 8'h16, 8'h08, 16'h0000, 1'b1, 1'b1, {8'hFF, 8'h01, 8'h34, 8'h12}, 1'b1);
    print_verdict();
  end
endmodule
